// >>> verilog/ring_walker_pkg.sv
// Shared types and constants for the packed descriptor ring walker.
// Assumes a single 100 MHz clock domain shared by all users of the package.
`default_nettype none

package ring_walker_pkg;

    // Descriptor flag bit positions
    localparam int F_NEXT  = 0;
    localparam int F_WRITE = 1;
    localparam int F_IND   = 2;
    localparam int F_AVAIL = 7;
    localparam int F_USED  = 15;

    localparam logic       WRAP_RST  = 1'b1;
    localparam logic [15:0] POS_RST  = 16'h0000;
    localparam logic [15:0] QSIZE_RST = 16'h0100;
    localparam logic [15:0] CAP_RST  = 16'h0000;
    localparam logic [63:0] BASE_RST = 64'h0000_0000_0000_0000;

    // Register byte offsets
    localparam logic [4:0] REG_CTRL    = 5'h00;
    localparam logic [4:0] REG_BASE_LO = 5'h04;
    localparam logic [4:0] REG_BASE_HI = 5'h08;
    localparam logic [4:0] REG_QSIZE   = 5'h0C;
    localparam logic [4:0] REG_CAP     = 5'h10;
    localparam logic [4:0] REG_STATUS  = 5'h14;
    localparam logic [4:0] REG_POS     = 5'h18;

    localparam int CTRL_EN      = 0;
    localparam int CTRL_INORDER = 1;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RD   = 5'h02,
        ST_ELEM = 5'h04,
        ST_DONE = 5'h08,
        ST_WR   = 5'h10
    } walk_st_e;

    typedef struct packed {
        logic [15:0] flags;
        logic [15:0] id;
        logic [31:0] len;
        logic [63:0] addr;
    } desc_s;

    typedef struct packed {
        logic        we;
        logic [63:0] addr;
        desc_s       wdata;
    } memreq_s;

    typedef struct packed {
        logic [63:0] addr;
        logic [31:0] len;
        logic [15:0] id;
        logic        wr;
        logic        last;
    } elem_s;

    typedef struct packed {
        logic        en;
        logic        in_order;
        logic [63:0] base;
        logic [15:0] qsize;
        logic [15:0] cap;
    } cfg_s;

    typedef struct packed {
        logic [15:0] apos;
        logic [15:0] upos;
        logic        awrap;
        logic        uwrap;
        logic        err;
        logic        busy;
    } stat_s;

endpackage

`default_nettype wire

// >>> verilog/ring_walker_regs.sv
// Avalon-MM register slave of the ring walker: configuration and status.
// Assumes a master that holds its request until it sees waitrequest low.
`default_nettype none

module ring_walker_regs (
    input  wire logic                   clk_in,
    input  wire logic                   nrst_in,
    input  wire logic [4:0]             avs_address_in,
    input  wire logic                   avs_read_in,
    input  wire logic                   avs_write_in,
    input  wire logic [31:0]            avs_writedata_in,
    input  wire logic [3:0]             avs_byteenable_in,
    output logic      [31:0]            avs_readdata_out,
    output logic                        avs_waitrequest_out,
    input  wire ring_walker_pkg::stat_s stat_in,
    output ring_walker_pkg::cfg_s       cfg_out
);
    import ring_walker_pkg::*;

    typedef struct packed {
        cfg_s        cfg;
        logic [31:0] rdata;
        logic        wait_req;
    } regs_s;

    regs_s r;
    regs_s next_r;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                v[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return v;
    endfunction

    always_comb begin
        next_r = r;
        next_r.wait_req = 1'b1;
        if ((avs_read_in || avs_write_in) && r.wait_req) begin
            // One wait cycle, then a one-cycle answer
            next_r.wait_req = 1'b0;
            next_r.rdata = 32'h0000_0000;
            if (avs_address_in == REG_CTRL) begin
                next_r.rdata = {30'h0, r.cfg.in_order, r.cfg.en};
            end else if (avs_address_in == REG_BASE_LO) begin
                next_r.rdata = r.cfg.base[31:0];
            end else if (avs_address_in == REG_BASE_HI) begin
                next_r.rdata = r.cfg.base[63:32];
            end else if (avs_address_in == REG_QSIZE) begin
                next_r.rdata = {16'h0000, r.cfg.qsize};
            end else if (avs_address_in == REG_CAP) begin
                next_r.rdata = {16'h0000, r.cfg.cap};
            end else if (avs_address_in == REG_STATUS) begin
                next_r.rdata = {28'h0, stat_in.uwrap, stat_in.awrap, stat_in.err, stat_in.busy};
            end else if (avs_address_in == REG_POS) begin
                next_r.rdata = {stat_in.upos, stat_in.apos};
            end
        end
        if (avs_write_in && !r.wait_req) begin
            if (avs_address_in == REG_CTRL) begin
                {next_r.cfg.in_order, next_r.cfg.en} =
                    2'(merge({30'h0, r.cfg.in_order, r.cfg.en}, avs_writedata_in, avs_byteenable_in));
            end else if (avs_address_in == REG_BASE_LO) begin
                next_r.cfg.base[31:0] = merge(r.cfg.base[31:0], avs_writedata_in, avs_byteenable_in);
            end else if (avs_address_in == REG_BASE_HI) begin
                next_r.cfg.base[63:32] = merge(r.cfg.base[63:32], avs_writedata_in, avs_byteenable_in);
            end else if (avs_address_in == REG_QSIZE) begin
                next_r.cfg.qsize = 16'(merge({16'h0000, r.cfg.qsize}, avs_writedata_in, avs_byteenable_in));
            end else if (avs_address_in == REG_CAP) begin
                next_r.cfg.cap = 16'(merge({16'h0000, r.cfg.cap}, avs_writedata_in, avs_byteenable_in));
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            r <= '{cfg: '{en: 1'b0, in_order: 1'b0, base: BASE_RST, qsize: QSIZE_RST, cap: CAP_RST},
                   rdata: 32'h0000_0000, wait_req: 1'b1};
        end else begin
            r <= next_r;
        end
    end

    assign avs_readdata_out    = r.rdata;
    assign avs_waitrequest_out = r.wait_req;
    assign cfg_out             = r.cfg;

endmodule

`default_nettype wire

// >>> verilog/ring_walker.sv
// Device-side walker of a packed descriptor ring in shared memory.
// Assumes a memory port that holds each request until mem_ack_in, with read data valid beside the ack.
//
// Behaviour
// - Both wrap counters reset to one
// - Device toggles wrap after consuming last slot
// - Offered flag bit 7, consumed flag bit 15
// - Device writes both flags equal to wrap
// - Poll only the next slot, wrapping to zero
// - Group write carries last id, then skip group
// - Writable bit; in consumed descriptor means data written
// - Consumed address unused, length gives bytes written
// - List length capped by limit or queue size
// - Chain bit on all but last; id in last
// - One consumed write per list, advance by length
// - Table bit: fetch table entries in order
// - In table honour only writable bit
// - Ignore writable bit of table-referencing descriptor
// - In-order batch: one write, skipped buffers consumed
// - Multi-buffer head marked after the rest
// - Act only when offered bit has changed
// - Start offered descriptors strictly in ring order
`default_nettype none

module ring_walker (
    input  wire logic                   clk_in,
    input  wire logic                   nrst_in,
    input  wire logic [4:0]             avs_address_in,
    input  wire logic                   avs_read_in,
    input  wire logic                   avs_write_in,
    input  wire logic [31:0]            avs_writedata_in,
    input  wire logic [3:0]             avs_byteenable_in,
    output logic      [31:0]            avs_readdata_out,
    output logic                        avs_waitrequest_out,
    output logic                        mem_req_out,
    output ring_walker_pkg::memreq_s    mem_out,
    input  wire logic                   mem_ack_in,
    input  wire ring_walker_pkg::desc_s mem_rdata_in,
    output logic                        elem_valid_out,
    output ring_walker_pkg::elem_s      elem_out,
    input  wire logic                   elem_ready_in,
    output logic                        done_ready_out,
    input  wire logic                   done_valid_in,
    input  wire logic [31:0]            done_len_in,
    input  wire logic                   done_defer_in
);
    import ring_walker_pkg::*;

    typedef struct packed {
        walk_st_e    st;
        logic [15:0] apos;
        logic        awrap;
        logic [15:0] upos;
        logic        uwrap;
        logic [15:0] lcnt;
        logic [15:0] pcnt;
        logic        pwr;
        logic [31:0] plen;
        logic        in_tbl;
        logic [63:0] taddr;
        logic [27:0] tleft;
        logic [15:0] tid;
        logic        mem_req;
        memreq_s     mem;
        logic        elem_valid;
        elem_s       elem;
        logic        done_ready;
        logic        err;
    } walk_s;

    walk_s s;
    walk_s next_s;
    cfg_s  cfg;
    stat_s stat;
    logic [15:0] cap;

    ring_walker_regs regs (
        .clk_in              (clk_in),
        .nrst_in             (nrst_in),
        .avs_address_in      (avs_address_in),
        .avs_read_in         (avs_read_in),
        .avs_write_in        (avs_write_in),
        .avs_writedata_in    (avs_writedata_in),
        .avs_byteenable_in   (avs_byteenable_in),
        .avs_readdata_out    (avs_readdata_out),
        .avs_waitrequest_out (avs_waitrequest_out),
        .stat_in             (stat),
        .cfg_out             (cfg)
    );

    // Byte address of a 16-byte ring slot
    function automatic logic [63:0] slot_addr(input logic [63:0] base, input logic [15:0] pos);
        return base + {44'h0, pos, 4'h0};
    endfunction

    // Advance a ring position; top bit says the end of the ring was passed
    function automatic logic [16:0] advance(input logic [15:0] pos, input logic [15:0] n,
                                            input logic [15:0] q);
        logic [16:0] sum;
        sum = {1'b0, pos} + {1'b0, n};
        if (sum >= {1'b0, q}) begin
            return {1'b1, 16'(sum - {1'b0, q})};
        end
        return {1'b0, sum[15:0]};
    endfunction

    // Offered: offered bit equals our wrap, consumed bit is its inverse
    function automatic logic offered(input logic [15:0] fl, input logic wrap);
        return (fl[F_AVAIL] == wrap) && (fl[F_USED] != wrap);
    endfunction

    assign cap  = (cfg.cap == 16'h0000 || cfg.cap > cfg.qsize) ? cfg.qsize : cfg.cap;
    assign stat = '{apos: s.apos, upos: s.upos, awrap: s.awrap, uwrap: s.uwrap,
                    err: s.err, busy: s.st != ST_IDLE};

    always_comb begin
        logic [16:0] adv;
        logic        wr_any;
        desc_s       d;
        adv    = 17'h0_0000;
        wr_any = 1'b0;
        d      = mem_rdata_in;
        next_s = s;
        if (!cfg.en && s.st == ST_IDLE) begin
            next_s.err = 1'b0;
        end
        case (s.st)
            ST_IDLE: begin
                if (cfg.en && !s.err && cfg.qsize != 16'h0000) begin
                    next_s.mem_req    = 1'b1;
                    next_s.mem.we     = 1'b0;
                    next_s.mem.addr   = slot_addr(cfg.base, s.apos);
                    next_s.st         = ST_RD;
                end
            end
            ST_RD: begin
                if (mem_ack_in) begin
                    next_s.mem_req = 1'b0;
                    if (s.in_tbl) begin
                        // Table entry: only the writable bit counts, id from ring
                        next_s.elem       = '{addr: d.addr, len: d.len, id: s.tid,
                                              wr: d.flags[F_WRITE], last: s.tleft == 28'h1};
                        next_s.tleft      = s.tleft - 28'h1;
                        next_s.taddr      = s.taddr + 64'h0000_0000_0000_0010;
                        next_s.elem_valid = 1'b1;
                        next_s.st         = ST_ELEM;
                    end else if (offered(d.flags, s.awrap)) begin
                        next_s.lcnt = s.lcnt + 16'h0001;
                        adv = advance(s.apos, 16'h0001, cfg.qsize);
                        next_s.apos  = adv[15:0];
                        next_s.awrap = s.awrap ^ adv[16];
                        if (s.lcnt >= cap) begin
                            next_s.err = 1'b1;
                            next_s.st  = ST_IDLE;
                        end else if (d.flags[F_IND]) begin
                            // Writable bit of this descriptor is ignored
                            next_s.in_tbl  = 1'b1;
                            next_s.taddr   = d.addr;
                            next_s.tleft   = d.len[31:4];
                            next_s.tid     = d.id;
                            if (d.len[31:4] == 28'h0) begin
                                next_s.err = 1'b1;
                                next_s.st  = ST_IDLE;
                            end else begin
                                next_s.mem_req  = 1'b1;
                                next_s.mem.addr = d.addr;
                            end
                        end else begin
                            next_s.elem       = '{addr: d.addr, len: d.len, id: d.id,
                                                  wr: d.flags[F_WRITE], last: !d.flags[F_NEXT]};
                            next_s.elem_valid = 1'b1;
                            next_s.st         = ST_ELEM;
                        end
                    end else begin
                        next_s.st = ST_IDLE;
                    end
                end
            end
            ST_ELEM: begin
                if (elem_ready_in) begin
                    next_s.elem_valid = 1'b0;
                    if (s.elem.last) begin
                        next_s.done_ready = 1'b1;
                        next_s.st         = ST_DONE;
                    end else if (s.in_tbl) begin
                        next_s.mem_req  = 1'b1;
                        next_s.mem.addr = s.taddr;
                        next_s.st       = ST_RD;
                    end else begin
                        next_s.st = ST_IDLE;
                    end
                end
            end
            ST_DONE: begin
                if (done_valid_in) begin
                    wr_any            = s.pwr || (done_len_in != 32'h0000_0000);
                    next_s.done_ready = 1'b0;
                    next_s.in_tbl     = 1'b0;
                    next_s.lcnt       = 16'h0000;
                    next_s.pcnt       = s.pcnt + s.lcnt;
                    next_s.pwr        = wr_any;
                    next_s.plen       = done_len_in;
                    if (done_defer_in && cfg.in_order) begin
                        next_s.st = ST_IDLE;
                    end else begin
                        // One write at the group's first slot, after all of it is done
                        next_s.mem_req   = 1'b1;
                        next_s.mem.we    = 1'b1;
                        next_s.mem.addr  = slot_addr(cfg.base, s.upos);
                        next_s.mem.wdata = '{flags: 16'h0000, id: s.elem.id,
                                             len: wr_any ? done_len_in : 32'h0000_0000,
                                             addr: 64'h0000_0000_0000_0000};
                        next_s.mem.wdata.flags[F_WRITE] = wr_any;
                        next_s.mem.wdata.flags[F_USED]  = s.uwrap;
                        next_s.mem.wdata.flags[F_AVAIL] = s.uwrap;
                        next_s.st = ST_WR;
                    end
                end
            end
            ST_WR: begin
                if (mem_ack_in) begin
                    adv = advance(s.upos, s.pcnt, cfg.qsize);
                    next_s.mem_req = 1'b0;
                    next_s.mem.we  = 1'b0;
                    next_s.upos    = adv[15:0];
                    next_s.uwrap   = s.uwrap ^ adv[16];
                    next_s.pcnt    = 16'h0000;
                    next_s.pwr     = 1'b0;
                    next_s.st      = ST_IDLE;
                end
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s       <= '0;
            s.st    <= ST_IDLE;
            s.apos  <= POS_RST;
            s.upos  <= POS_RST;
            s.awrap <= WRAP_RST;
            s.uwrap <= WRAP_RST;
        end else begin
            s <= next_s;
        end
    end

    assign mem_req_out    = s.mem_req;
    assign mem_out        = s.mem;
    assign elem_valid_out = s.elem_valid;
    assign elem_out       = s.elem;
    assign done_ready_out = s.done_ready;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    used_flags_a: assert property (s.mem_req && s.mem.we |->
        s.mem.wdata.flags[F_USED] == s.uwrap && s.mem.wdata.flags[F_AVAIL] == s.uwrap)
        else $error("consumed flags do not equal wrap counter");
    wrap_turn_a: assert property ($changed(s.uwrap) |->
        $past(s.st) == ST_WR && $past(mem_ack_in))
        else $error("wrap counter toggled outside a consumed write");
    addr_zero_a: assert property (s.mem_req && s.mem.we |-> s.mem.wdata.addr == 64'h0)
        else $error("consumed descriptor address not zero");
    len_resv_a: assert property (s.mem_req && s.mem.we && !s.mem.wdata.flags[F_WRITE] |->
        s.mem.wdata.len == 32'h0)
        else $error("length set without written flag");
    pos_range_a: assert property (cfg.qsize != 16'h0 && $stable(cfg.qsize) |->
        s.apos < cfg.qsize && s.upos < cfg.qsize)
        else $error("ring position beyond queue size");
    cap_a: assert property (!s.err && $stable(cap) |-> s.lcnt <= cap)
        else $error("list longer than cap");
    poll_addr_a: assert property (s.mem_req && !s.mem.we && !s.in_tbl |->
        s.mem.addr == slot_addr(cfg.base, s.apos))
        else $error("poll not at next ring slot");
    offered_a: assert property ($rose(s.elem_valid) && !s.in_tbl |->
        $past(mem_rdata_in.flags[F_AVAIL]) != $past(mem_rdata_in.flags[F_USED]))
        else $error("element taken from descriptor not offered");

    elem_c: cover property (s.elem_valid && elem_ready_in && s.elem.last);
    write_c: cover property (s.st == ST_WR && mem_ack_in);
    wrap_c: cover property ($changed(s.uwrap));
    table_c: cover property (s.in_tbl && s.elem_valid && elem_ready_in);

endmodule

`default_nettype wire

// >>> tb/ring_mem_model.sv
// Shared-memory model of the descriptor ring and tables, as seen on the walker's memory port.
// Assumes the walker holds each request until acknowledged; slow_in adds wait cycles.
`default_nettype none

module ring_mem_model (
    input  wire logic                     clk_in,
    input  wire logic                     nrst_in,
    input  wire logic [1:0]               slow_in,
    input  wire logic                     mem_req_in,
    input  wire ring_walker_pkg::memreq_s mem_in,
    output logic                          mem_ack_out,
    output ring_walker_pkg::desc_s        mem_rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import ring_walker_pkg::*;

    desc_s      ram [0:127];
    logic [1:0] cnt;
    wire  [6:0] idx = mem_in.addr[10:4];

    // The ring starts all zero, so no slot looks offered before the driver writes it
    initial begin
        foreach (ram[i]) begin
            ram[i] = '0;
        end
    end

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mem_ack_out   <= 1'b0;
            mem_rdata_out <= '0;
            cnt           <= 2'h0;
        end else if (mem_req_in && !mem_ack_out && cnt >= slow_in) begin
            mem_ack_out   <= 1'b1;
            mem_rdata_out <= ram[idx];
            cnt           <= 2'h0;
            if (mem_in.we) begin
                ram[idx] <= mem_in.wdata;
            end
        end else begin
            // Outside an answer the read data is scrambled, never held
            mem_ack_out   <= 1'b0;
            mem_rdata_out <= ~mem_rdata_out;
            cnt           <= mem_req_in ? cnt + 2'h1 : 2'h0;
        end
    end
endmodule

`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench of the ring walker: registers, single, chained, table and batched lists.
// Assumes the ring memory model answers the walker's memory port.
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ring_walker_pkg::*;

    typedef struct {logic [4:0] a; logic [31:0] v;} row_s;
    logic        clk_in, nrst_in, avs_read, avs_write, avs_wait, mem_req, mem_ack;
    logic        elem_valid, elem_ready, done_ready, done_valid, done_defer, seen;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, done_len, q;
    logic [1:0]  slow;
    memreq_s     mem_q;
    desc_s       mem_rd;
    elem_s       elem;
    int          n_fail, compares;
    row_s        rows [8] = '{'{REG_CTRL, 32'h0000_0000}, '{REG_QSIZE, 32'h0000_0100}, '{REG_CAP, 32'h0000_0000},
                              '{REG_STATUS, 32'h0000_000C}, '{REG_POS, 32'h0000_0000}, '{5'h1C, 32'h0000_0000},
                              '{REG_BASE_LO, 32'h0000_0000}, '{REG_BASE_HI, 32'h0000_0000}};

    ring_walker dut (.clk_in(clk_in), .nrst_in(nrst_in), .avs_address_in(avs_address), .avs_read_in(avs_read),
        .avs_write_in(avs_write), .avs_writedata_in(avs_writedata), .avs_byteenable_in(4'hF),
        .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_wait), .mem_req_out(mem_req), .mem_out(mem_q),
        .mem_ack_in(mem_ack), .mem_rdata_in(mem_rd), .elem_valid_out(elem_valid), .elem_out(elem),
        .elem_ready_in(elem_ready), .done_ready_out(done_ready), .done_valid_in(done_valid),
        .done_len_in(done_len), .done_defer_in(done_defer));
    ring_mem_model mem (.clk_in(clk_in), .nrst_in(nrst_in), .slow_in(slow), .mem_req_in(mem_req),
        .mem_in(mem_q), .mem_ack_out(mem_ack), .mem_rdata_out(mem_rd));

    task automatic complete_run();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_in);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk_in);
        end while (avs_wait !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic put(int i, logic [15:0] f, logic [15:0] id, logic [63:0] ad, logic [31:0] ln);
        mem.ram[i] = '{f, id, ln, ad};
    endtask

    task automatic take(input elem_s exp);
        @(negedge clk_in);
        while (elem_valid !== 1'b1) begin
            @(negedge clk_in);
        end
        `CHK(elem, exp)
        @(posedge clk_in);
        elem_ready <= 1'b1;
        @(posedge clk_in);
        elem_ready <= 1'b0;
    endtask

    task automatic finish_list(input logic [31:0] ln, input logic defer);
        @(negedge clk_in);
        while (done_ready !== 1'b1) begin
            @(negedge clk_in);
        end
        @(posedge clk_in);
        done_valid <= 1'b1;
        done_len   <= ln;
        done_defer <= defer;
        @(posedge clk_in);
        done_valid <= 1'b0;
        if (!defer) begin
            while (!(mem_req === 1'b1 && mem_q.we === 1'b1)) begin
                @(negedge clk_in);
            end
            while (mem_req !== 1'b0) begin
                @(negedge clk_in);
            end
        end
    endtask

    task automatic slot(int i, logic [15:0] f, logic [15:0] id, logic [31:0] ln);
        `CHK({mem.ram[i].flags, mem.ram[i].id}, {f, id})
        if (f[F_WRITE]) `CHK(mem.ram[i].len, ln)
    endtask

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    initial begin
        #200000;
        n_fail++;
        complete_run();
    end

    initial begin
        {nrst_in, avs_read, avs_write, elem_ready, done_valid, done_defer, seen} = '0;
        {avs_address, avs_writedata, done_len, slow, n_fail, compares} = '0;
        repeat (4) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(negedge clk_in);
        `CHK({avs_wait, mem_req, elem_valid, done_ready}, 4'h8)
        foreach (rows[i]) begin
            bus(1'b0, rows[i].a, 32'h0000_0000);
            `CHK(q, rows[i].v)
        end
        bus(1'b1, REG_QSIZE, 32'h0000_0004);
        bus(1'b1, REG_CTRL, 32'h0000_0001);
        repeat (20) begin
            @(negedge clk_in);
            seen |= elem_valid;
        end
        `CHK(seen, 1'b0)
        put(0, 16'h0082, 16'h0011, 64'h1000, 32'h0000_0040);
        take('{64'h1000, 32'h0000_0040, 16'h0011, 1'b1, 1'b1});
        finish_list(32'h0000_0005, 1'b0);
        slot(0, 16'h8082, 16'h0011, 32'h0000_0005);
        slow = 2'h2;
        put(2, 16'h0080, 16'h0007, 64'h2000, 32'h0000_0008);
        put(1, 16'h0081, 16'h0006, 64'h1800, 32'h0000_0004);
        take('{64'h1800, 32'h0000_0004, 16'h0006, 1'b0, 1'b0});
        take('{64'h2000, 32'h0000_0008, 16'h0007, 1'b0, 1'b1});
        finish_list(32'h0000_0000, 1'b0);
        slot(1, 16'h8080, 16'h0007, 32'h0000_0000);
        `CHK(mem.ram[2].flags, 16'h0080)
        slow = 2'h0;
        put(64, 16'h0083, 16'h0055, 64'h3000, 32'h0000_0010);
        put(65, 16'h8000, 16'h0066, 64'h3100, 32'h0000_0020);
        put(3, 16'h0086, 16'h0009, 64'h0400, 32'h0000_0020);
        take('{64'h3000, 32'h0000_0010, 16'h0009, 1'b1, 1'b0});
        take('{64'h3100, 32'h0000_0020, 16'h0009, 1'b0, 1'b1});
        finish_list(32'h0000_0000, 1'b0);
        slot(3, 16'h8080, 16'h0009, 32'h0000_0000);
        bus(1'b0, REG_STATUS, 32'h0000_0000);
        `CHK(q[3:2], 2'h0)
        bus(1'b0, REG_POS, 32'h0000_0000);
        `CHK(q, 32'h0000_0000)
        bus(1'b1, REG_CTRL, 32'h0000_0003);
        put(1, 16'h8000, 16'h0021, 64'h5000, 32'h0000_0010);
        put(0, 16'h8000, 16'h0020, 64'h4000, 32'h0000_0010);
        take('{64'h4000, 32'h0000_0010, 16'h0020, 1'b0, 1'b1});
        finish_list(32'h0000_0003, 1'b1);
        take('{64'h5000, 32'h0000_0010, 16'h0021, 1'b0, 1'b1});
        finish_list(32'h0000_0000, 1'b0);
        slot(0, 16'h0002, 16'h0021, 32'h0000_0000);
        `CHK(mem.ram[1].flags, 16'h8000)
        bus(1'b0, REG_POS, 32'h0000_0000);
        `CHK(q, 32'h0002_0002)
        bus(1'b1, REG_CAP, 32'h0000_0001);
        put(3, 16'h8000, 16'h0031, 64'h6100, 32'h0000_0010);
        put(2, 16'h8001, 16'h0000, 64'h6000, 32'h0000_0010);
        take('{64'h6000, 32'h0000_0010, 16'h0000, 1'b0, 1'b0});
        repeat (8) @(posedge clk_in);
        bus(1'b0, REG_STATUS, 32'h0000_0000);
        `CHK({q[1], elem_valid}, 2'h2)
        nrst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        bus(1'b0, REG_STATUS, 32'h0000_0000);
        `CHK(q, 32'h0000_000C)
        bus(1'b0, REG_POS, 32'h0000_0000);
        `CHK(q, 32'h0000_0000)
        complete_run();
    end
endmodule

`default_nettype wire
